// file: rtl/ofmc_defs.svh
`ifndef OFMC_DEFS_SVH
`define OFMC_DEFS_SVH

// ----------------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------------
`define OFMC_RW_BIT        31
`define OFMC_ID_MSB        30
`define OFMC_ID_LSB        26
`define OFMC_ID_CONFIG     5'h07
`define OFMC_ID_DIAG_READ  5'h09
`define OFMC_HDR_MASK      32'hFC000000
`define OFMC_CFG_MASK      32'h00FFF800
`define OFMC_CFG_RESET     32'h00000000

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define OFMC_CM_TOP        23
`define OFMC_FM_TOP        19
`define OFMC_EN_MASK_BIT   15
`define OFMC_RB_MASK_BIT   14
`define OFMC_TIMER_SEL_MSB 13
`define OFMC_TIMER_SEL_LSB 12
`define OFMC_AUTO_ZERO_BIT 11

// ----------------------------------------------------------------------------
// timer pre-divider values
// ----------------------------------------------------------------------------
`define OFMC_PREDIV_128    9'h080
`define OFMC_PREDIV_192    9'h0C0
`define OFMC_PREDIV_256    9'h100

// ----------------------------------------------------------------------------
// link framing
// ----------------------------------------------------------------------------
`define OFMC_BIT_LAST      5'h1F
`define OFMC_BIT_FIRST_TX  5'h01

`endif

// file: rtl/ofmc_pkg.sv
`default_nettype none

package ofmc_pkg;
  typedef logic [31:0] ofmc_word_type;
  typedef logic [4:0]  ofmc_bit_cnt_type;
  typedef logic [8:0]  ofmc_prediv_type;
endpackage

`default_nettype wire

// file: rtl/ofmc_spi_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofmc_defs.svh"

module ofmc_spi_link
  import ofmc_pkg::*;
(
  // link pins
  input  wire logic          spi_clk_in,
  input  wire logic          spi_cs_n_in,
  input  wire logic          spi_mosi_in,
  output logic               spi_miso_out,
  output logic               spi_miso_oe_out,
  // reset
  input  wire logic          rst_n_in,
  // system side
  input  wire ofmc_word_type tx_word_in,
  output ofmc_word_type      rx_word_out,
  output logic               rx_toggle_out
);

  ofmc_bit_cnt_type bit_cnt_reg, bit_cnt_next;
  ofmc_word_type    rx_sh_reg, rx_sh_next;
  ofmc_word_type    tx_sh_reg, tx_sh_next;
  ofmc_word_type    rx_word_reg, rx_word_next;
  logic             rx_toggle_reg, rx_toggle_next;
  logic             frame_rst;

  // frame logic is cleared by the frame's own select, not by any late edge
  assign frame_rst = spi_cs_n_in | ~rst_n_in;

  // --------------------------------------------------------------------------
  // receive shifter, mode 0, msb first
  // --------------------------------------------------------------------------
  always_comb begin
    bit_cnt_next   = bit_cnt_reg + 5'h01;
    rx_sh_next     = {rx_sh_reg[30:0], spi_mosi_in};
    rx_word_next   = rx_word_reg;
    rx_toggle_next = rx_toggle_reg;
    if (bit_cnt_reg == `OFMC_BIT_LAST) begin
      rx_word_next   = rx_sh_next;
      rx_toggle_next = ~rx_toggle_reg;
    end
  end

  always_ff @(posedge spi_clk_in or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_reg <= 5'h00;
      rx_sh_reg   <= 32'h00000000;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      rx_sh_reg   <= rx_sh_next;
    end
  end

  // held word and event toggle outlive the frame
  always_ff @(posedge spi_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_word_reg   <= 32'h00000000;
      rx_toggle_reg <= 1'b0;
    end else begin
      rx_word_reg   <= rx_word_next;
      rx_toggle_reg <= rx_toggle_next;
    end
  end

  // --------------------------------------------------------------------------
  // transmit shifter, changes on falling edge
  // --------------------------------------------------------------------------
  always_comb begin
    tx_sh_next = {tx_sh_reg[30:0], 1'b0};
    if (bit_cnt_reg == `OFMC_BIT_FIRST_TX) begin
      tx_sh_next = {tx_word_in[30:0], 1'b0};
    end
  end

  always_ff @(negedge spi_clk_in or posedge frame_rst) begin
    if (frame_rst) begin
      tx_sh_reg <= 32'h00000000;
    end else begin
      tx_sh_reg <= tx_sh_next;
    end
  end

  assign spi_miso_out    = (bit_cnt_reg == 5'h00) ? tx_word_in[31] : tx_sh_reg[31];
  assign spi_miso_oe_out = ~spi_cs_n_in;
  assign rx_word_out     = rx_word_reg;
  assign rx_toggle_out   = rx_toggle_reg;

endmodule // ofmc_spi_link

`default_nettype wire

// file: rtl/ofmc_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofmc_defs.svh"

module ofmc_config
  import ofmc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // spi link
  input  wire logic       spi_clk_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic       spi_mosi_in,
  output logic            spi_miso_out,
  output logic            spi_miso_oe_out,
  // device pins
  input  wire logic       enable_pin_in,
  input  wire logic       reset_pin_n_in,
  output logic            fault_pin_out,
  // core side
  input  wire logic [3:0] channel_fault_in,
  output logic [3:0]      channel_control_mode_out,
  output logic [1:0]      diagnostic_timer_select_out,
  output ofmc_prediv_type diag_prediv_out,
  output logic            auto_zero_off_out,
  output logic            enable_fault_latch_out
);

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  function automatic logic id_is(input ofmc_word_type w, input logic [4:0] id);
    id_is = (w[`OFMC_ID_MSB:`OFMC_ID_LSB] == id);
  endfunction

  function automatic ofmc_prediv_type prediv_of(input logic [1:0] sel);
    prediv_of = `OFMC_PREDIV_128;
    unique case (sel)
      2'h0:       prediv_of = `OFMC_PREDIV_128;
      2'h1, 2'h2: prediv_of = `OFMC_PREDIV_192;
      2'h3:       prediv_of = `OFMC_PREDIV_256;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // link side
  // --------------------------------------------------------------------------
  ofmc_word_type rx_word;
  logic          rx_toggle;
  ofmc_word_type tx_word_reg, tx_word_next;

  ofmc_spi_link u_link (
    .spi_clk_in      (spi_clk_in),
    .spi_cs_n_in     (spi_cs_n_in),
    .spi_mosi_in     (spi_mosi_in),
    .spi_miso_out    (spi_miso_out),
    .spi_miso_oe_out (spi_miso_oe_out),
    .rst_n_in        (rst_n_in),
    .tx_word_in      (tx_word_reg),
    .rx_word_out     (rx_word),
    .rx_toggle_out   (rx_toggle)
  );

  // --------------------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------------------
  logic tog_meta_reg, tog_sync_reg, tog_seen_reg;
  logic en_meta_reg, en_sync_reg, en_prev_reg;
  logic rb_meta_reg, rb_sync_reg;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      tog_seen_reg <= 1'b0;
      en_meta_reg  <= 1'b1;
      en_sync_reg  <= 1'b1;
      en_prev_reg  <= 1'b1;
      rb_meta_reg  <= 1'b1;
      rb_sync_reg  <= 1'b1;
    end else begin
      tog_meta_reg <= rx_toggle;
      tog_sync_reg <= tog_meta_reg;
      tog_seen_reg <= tog_sync_reg;
      en_meta_reg  <= enable_pin_in;
      en_sync_reg  <= en_meta_reg;
      en_prev_reg  <= en_sync_reg;
      rb_meta_reg  <= reset_pin_n_in;
      rb_sync_reg  <= rb_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // frame decode and configuration state
  // --------------------------------------------------------------------------
  logic          rx_evt, cfg_hit, cfg_wr, diag_rd, en_fell;
  ofmc_word_type cfg_reg, cfg_next;
  logic          en_latch_reg, en_latch_next;
  logic          fault_reg, fault_next;
  ofmc_prediv_type prediv_reg, prediv_next;

  // rx_word is stable here: it only changes at the end of the next frame
  assign rx_evt  = tog_sync_reg ^ tog_seen_reg;
  assign cfg_hit = rx_evt & id_is(rx_word, `OFMC_ID_CONFIG);
  assign cfg_wr  = cfg_hit & rx_word[`OFMC_RW_BIT];
  assign diag_rd = rx_evt & id_is(rx_word, `OFMC_ID_DIAG_READ);
  assign en_fell = en_prev_reg & ~en_sync_reg;

  always_comb begin
    cfg_next      = cfg_reg;
    tx_word_next  = tx_word_reg;
    en_latch_next = en_latch_reg;
    if (cfg_wr) begin
      cfg_next = rx_word & `OFMC_CFG_MASK;
    end
    if (rx_evt) begin
      tx_word_next = 32'h00000000;
      if (cfg_hit) begin
        tx_word_next = (rx_word & `OFMC_HDR_MASK) | cfg_next;
      end
    end
    // set wins over a clear in the same cycle
    if (diag_rd && en_sync_reg) begin
      en_latch_next = 1'b0;
    end
    if (en_fell) begin
      en_latch_next = 1'b1;
    end
    // pre-divider registered with the settings it decodes
    prediv_next = prediv_of(cfg_next[`OFMC_TIMER_SEL_MSB:`OFMC_TIMER_SEL_LSB]);
    fault_next = ((en_latch_reg | ~en_sync_reg) & cfg_reg[`OFMC_EN_MASK_BIT])
               | (~rb_sync_reg & cfg_reg[`OFMC_RB_MASK_BIT]);
    for (int i = 0; i < 4; i++) begin
      fault_next = fault_next | (channel_fault_in[i] & cfg_reg[`OFMC_FM_TOP - i]);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_reg      <= `OFMC_CFG_RESET;
      tx_word_reg  <= 32'h00000000;
      en_latch_reg <= 1'b0;
      fault_reg    <= 1'b0;
      prediv_reg   <= `OFMC_PREDIV_128;
    end else begin
      prediv_reg   <= prediv_next;
      cfg_reg      <= cfg_next;
      tx_word_reg  <= tx_word_next;
      en_latch_reg <= en_latch_next;
      fault_reg    <= fault_next;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_mode
      assign channel_control_mode_out[g] = cfg_reg[`OFMC_CM_TOP - g];
    end
  endgenerate

  assign diagnostic_timer_select_out = cfg_reg[`OFMC_TIMER_SEL_MSB:`OFMC_TIMER_SEL_LSB];
  assign diag_prediv_out             = prediv_reg;
  assign auto_zero_off_out           = cfg_reg[`OFMC_AUTO_ZERO_BIT];
  assign enable_fault_latch_out      = en_latch_reg;
  assign fault_pin_out               = fault_reg;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  logic seen_wr_reg;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seen_wr_reg <= 1'b0;
    end else if (cfg_wr) begin
      seen_wr_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_write_takes: assert property (cfg_wr |=>
    channel_control_mode_out[0] == $past(rx_word[23]) && auto_zero_off_out == $past(rx_word[11]))
    else $error("config write not taken");
  chk_read_keeps: assert property (cfg_hit && !cfg_wr |=> $stable(cfg_reg))
    else $error("config read changed settings");
  chk_mode_order: assert property (cfg_wr && rx_word[20] |=> channel_control_mode_out[3])
    else $error("channel 3 mode bit misplaced");
  chk_masked_fault: assert property ((channel_fault_in & {cfg_reg[16], cfg_reg[17],
    cfg_reg[18], cfg_reg[19]}) != 4'h0 |=> fault_pin_out)
    else $error("unmasked channel fault missed");
  chk_quiet_fault: assert property (channel_fault_in == 4'hF && cfg_reg[19:14] == 6'h00
    |=> !fault_pin_out)
    else $error("masked fault reached pin");
  chk_enable_fault: assert property (cfg_reg[15] && !en_sync_reg |=> fault_pin_out)
    else $error("enable low did not raise fault");
  chk_reset_fault: assert property (cfg_reg[14] && !rb_sync_reg |=> fault_pin_out)
    else $error("reset low did not raise fault");
  chk_latch_set: assert property (en_fell |=> en_latch_reg)
    else $error("enable fall not latched");
  chk_latch_hold: assert property (en_latch_reg && !(diag_rd && en_sync_reg)
    |=> en_latch_reg)
    else $error("enable latch dropped early");
  chk_prediv_map: assert property (cfg_wr && rx_word[13:12] == 2'h2
    |=> diag_prediv_out == 9'h0C0 [*2])
    else $error("pre-divider select wrong");
  chk_auto_zero: assert property (cfg_wr && !rx_word[11] |=> !auto_zero_off_out)
    else $error("auto-zero control wrong");
  chk_reset_zero: assert property (!seen_wr_reg |-> cfg_reg == 32'h00000000)
    else $error("settings not zero before first write");
  chk_resp_unused: assert property (tx_word_reg[25:24] == 2'h0 && tx_word_reg[10:0] == 11'h000)
    else $error("response unused bits not zero");

  cov_write: cover property (cfg_wr);
  cov_refused: cover property (rx_evt && !cfg_hit);
  cov_latch_clear: cover property (en_latch_reg ##1 !en_latch_reg);
  cov_fault: cover property ($rose(fault_pin_out));

endmodule // ofmc_config

`default_nettype wire

// file: bench/ofmc_host.sv
`timescale 1ns/1ps
`default_nettype none

module ofmc_host
  import ofmc_pkg::*;
(
  // link pins
  output logic      spi_clk_out,
  output logic      spi_cs_n_out,
  output logic      spi_mosi_out,
  input  wire logic spi_miso_in
);
  // --------------------------------------------------------------------------
  // idle levels
  // --------------------------------------------------------------------------
  initial begin
    spi_clk_out  = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b1;
  end

  // --------------------------------------------------------------------------
  // one frame: 32 bits msb first, clock only inside the frame
  // --------------------------------------------------------------------------
  task automatic frame(input ofmc_word_type tx, output ofmc_word_type rx);
    spi_cs_n_out = 1'b0;
    spi_mosi_out = tx[31];
    #6;
    for (int i = 31; i >= 0; i--) begin
      // sample ahead of the edge so the design's update cannot race it
      rx[i] = spi_miso_in;
      spi_clk_out = 1'b1;
      #6;
      spi_clk_out = 1'b0;
      spi_mosi_out = (i > 0) ? tx[(i+31)%32] : ~tx[0];
      #6;
    end
    spi_cs_n_out = 1'b1;
  endtask
endmodule // ofmc_host

`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofmc_defs.svh"

module testbench
  import ofmc_pkg::*;
;
  typedef struct {
    ofmc_word_type   word;
    logic [3:0]      mode;
    logic [1:0]      tmr;
    ofmc_prediv_type prediv;
    logic            az;
  } ofmc_row_type;

  logic            sys_clk, rst_n, spi_clk, cs_n, mosi, miso, miso_oe;
  logic            en_pin, rst_pin_n, fault, az, latch;
  logic [3:0]      ch_fault, mode;
  logic [1:0]      tmr;
  ofmc_prediv_type prediv;
  ofmc_word_type   rx;
  int              n_mismatch, samples_checked;
  ofmc_row_type    rows [4] = '{
    '{32'h00800000, 4'h1, 2'h0, `OFMC_PREDIV_128, 1'b0},
    '{32'h00101800, 4'h8, 2'h1, `OFMC_PREDIV_192, 1'b1},
    '{32'h00602000, 4'h6, 2'h2, `OFMC_PREDIV_192, 1'b0},
    '{32'h00F03800, 4'hF, 2'h3, `OFMC_PREDIV_256, 1'b1}};

  // --------------------------------------------------------------------------
  // design and host
  // --------------------------------------------------------------------------
  ofmc_config i_ofmc_config (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .spi_clk_in(spi_clk),
    .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oe_out(miso_oe), .enable_pin_in(en_pin), .reset_pin_n_in(rst_pin_n),
    .fault_pin_out(fault), .channel_fault_in(ch_fault),
    .channel_control_mode_out(mode), .diagnostic_timer_select_out(tmr),
    .diag_prediv_out(prediv), .auto_zero_off_out(az), .enable_fault_latch_out(latch));

  ofmc_host i_ofmc_host (
    .spi_clk_out(spi_clk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi),
    .spi_miso_in(miso));

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // mode, tmr, prediv, az, fault, latch
  task automatic outs(input logic [17:0] exp);
    chk("outputs", {14'h0000, exp}, {14'h0000, mode, tmr, prediv, az, fault, latch});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic xfer(input ofmc_word_type tx);
    i_ofmc_host.frame(tx, rx);
    step(8);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // clock, watchdog
  // --------------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    #100us;
    n_mismatch++;
    $display("watchdog expired");
    results();
  end

  // --------------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    en_pin = 1'b1;
    rst_pin_n = 1'b1;
    ch_fault = 4'h0;
    step(5);
    rst_n = 1'b1;
    step(2);
    outs({4'h0, 2'h0, `OFMC_PREDIV_128, 3'b000});
    chk("miso drive", 32'h0, {31'h0, miso_oe});
    fork
      i_ofmc_host.frame(32'h1C000000, rx);
      begin
        #100;
        chk("miso drive", 32'h1, {31'h0, miso_oe});
      end
    join
    step(8);
    chk("miso drive", 32'h0, {31'h0, miso_oe});
    xfer(32'h1C000000);
    chk("response", 32'h1C000000, rx);
    $display("test reset done");
    ch_fault = 4'hF;
    foreach (rows[i]) begin
      xfer(rows[i].word | 32'h9F0007FF);
      outs({rows[i].mode, rows[i].tmr, rows[i].prediv, rows[i].az, 2'b00});
      xfer(32'h1C000000);
      chk("response", rows[i].word | 32'h9C000000, rx);
    end
    $display("test rows done");
    xfer(32'hA0FFF800);
    xfer(32'h1CFFFFFF);
    chk("response", 32'h00000000, rx);
    outs({4'hF, 2'h3, `OFMC_PREDIV_256, 3'b100});
    $display("test refusal done");
    for (int j = 0; j < 4; j++) begin
      xfer(32'h9C000000 | (32'h00080000 >> j));
      for (int i = 0; i < 4; i++) begin
        ch_fault = 4'h1 << i;
        step(2);
        chk("fault", 32'(i == j), {31'h0, fault});
      end
    end
    ch_fault = 4'h0;
    $display("test masks done");
    xfer(32'h9C008000);
    en_pin = 1'b0;
    step(4);
    outs({4'h0, 2'h0, `OFMC_PREDIV_128, 3'b011});
    xfer(32'h24000000);
    outs({4'h0, 2'h0, `OFMC_PREDIV_128, 3'b011});
    en_pin = 1'b1;
    step(4);
    outs({4'h0, 2'h0, `OFMC_PREDIV_128, 3'b011});
    xfer(32'h24000000);
    outs({4'h0, 2'h0, `OFMC_PREDIV_128, 3'b000});
    xfer(32'h9C000000);
    en_pin = 1'b0;
    step(4);
    outs({4'h0, 2'h0, `OFMC_PREDIV_128, 3'b001});
    en_pin = 1'b1;
    step(4);
    xfer(32'h24000000);
    $display("test enable done");
    xfer(32'h9C004000);
    rst_pin_n = 1'b0;
    step(4);
    chk("fault", 32'h1, {31'h0, fault});
    xfer(32'h9C000000);
    chk("fault", 32'h0, {31'h0, fault});
    rst_pin_n = 1'b1;
    $display("test reset pin done");
    xfer(32'h9CF03800);
    rst_n = 1'b0;
    step(2);
    outs({4'h0, 2'h0, `OFMC_PREDIV_128, 3'b000});
    rst_n = 1'b1;
    step(2);
    $display("test second reset done");
    results();
  end
endmodule // testbench

`default_nettype wire
